// ### hw/frame_receiver.sv
// Purpose: Serial-clock side shifter that collects one 24-bit frame.
// Assumes: Frame strobe is active low and idles high between frames.
// Notes:   Frame-sync high acts as an asynchronous clear of the shifter.
`timescale 1ns/1ps
`default_nettype none
module frame_receiver #(
   parameter int FRAME_BITS = quad_dac_pkg::FRAME_BITS
) (
   input  wire logic                  sclk,
   input  wire logic                  rst_n,
   input  wire logic                  sync_n,
   input  wire logic                  sdin,
   output logic [FRAME_BITS-1:0]      frame_word,
   output logic                       frame_toggle
);
   localparam int CW = $clog2(FRAME_BITS + 1);

   // Field positions reach bit 21, so a shorter frame cannot be decoded
   if (FRAME_BITS < 24) begin : g_bad_width
      $error("frame_receiver: frame too short");
   end

   logic [FRAME_BITS-1:0] frame_shift_reg_ff; // Incoming bits
   logic [CW-1:0]         count_ff;           // Falling edges in this frame
   wire                   abort_n = rst_n & ~sync_n; // Strobe high clears

   // Shift MSB first on falling edges; locks after the last bit
   always_ff @(negedge sclk or negedge abort_n) begin
      if (!abort_n) begin
         frame_shift_reg_ff <= '0;
         count_ff           <= '0;
      end else if (count_ff != CW'(FRAME_BITS)) begin
         frame_shift_reg_ff <= {frame_shift_reg_ff[FRAME_BITS-2:0], sdin};
         count_ff           <= count_ff + 1'b1;
      end
   end

   // Word captured on the final edge, held for the core domain
   always_ff @(negedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         frame_word   <= '0;
         frame_toggle <= 1'b0;
      end else if (!sync_n && count_ff == CW'(FRAME_BITS - 1)) begin
         frame_word   <= {frame_shift_reg_ff[FRAME_BITS-2:0], sdin};
         frame_toggle <= ~frame_toggle;          // Only complete frames signal
      end
   end
endmodule
`default_nettype wire

// ### hw/quad_dac_command_decoder.sv
// Purpose: Decode completed frames into channel buffers, DAC registers and modes.
// Assumes: Serial clock stops or runs freely; frame word is stable for many core cycles.
// Notes:   Crossing is a toggle event plus a held word; host must space frames.
`timescale 1ns/1ps
`default_nettype none
module quad_dac_command_decoder (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        sclk,
   input  wire logic        sync_n,
   input  wire logic        sdin,
   output logic [11:0]      dac_a_ff,
   output logic [11:0]      dac_b_ff,
   output logic [11:0]      dac_c_ff,
   output logic [11:0]      dac_d_ff,
   output logic [1:0]       mode_a_ff,
   output logic [1:0]       mode_b_ff,
   output logic [1:0]       mode_c_ff,
   output logic [1:0]       mode_d_ff,
   output logic             update_pulse_ff
);
   localparam int FB = quad_dac_pkg::FRAME_BITS;
   localparam int NC = quad_dac_pkg::CHANNELS;

   logic [FB-1:0] frame_word;   // Held word from the link domain
   logic          frame_toggle; // Flips once per complete frame

   // Link-side receiver on the serial clock
   frame_receiver #(
      .FRAME_BITS (FB)
   ) u_rx (
      .sclk         (sclk),
      .rst_n        (rst_n),
      .sync_n       (sync_n),
      .sdin         (sdin),
      .frame_word   (frame_word),
      .frame_toggle (frame_toggle)
   );

   // Toggle synchroniser; first stage feeds only the second
   // A toggle rather than a level pulse, so a slow or stopped link clock still
   // delivers exactly one event per frame to the core domain
   logic tog_s1_ff; // First stage, may be metastable
   logic tog_s2_ff; // Second stage, safe to use
   logic tog_s3_ff; // Delayed copy for edge detection
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tog_s1_ff <= 1'b0;
         tog_s2_ff <= 1'b0;
         tog_s3_ff <= 1'b0;
      end else begin
         tog_s1_ff <= frame_toggle;
         tog_s2_ff <= tog_s1_ff;
         tog_s3_ff <= tog_s2_ff;
      end
   end
   // Event stands one core cycle; the held word is only read then
   wire frame_evt = tog_s2_ff ^ tog_s3_ff; // One pulse per finished frame

   // Frame fields; word is settled by the time the event arrives
   // Fields are decoded combinationally; only frame_evt lets them into state
   wire        load_ctrl_hi      = frame_word[quad_dac_pkg::LOAD_HI_POS];
   wire        load_ctrl_lo      = frame_word[quad_dac_pkg::LOAD_LO_POS];
   wire [1:0]  sel               = {frame_word[quad_dac_pkg::SEL_HI_POS],
                                    frame_word[quad_dac_pkg::SEL_LO_POS]};
   wire        powerdown_flag    = frame_word[quad_dac_pkg::PD_FLAG_POS];
   wire        powerdown_mode_hi = frame_word[quad_dac_pkg::PD_MODE_HI_POS];
   wire        powerdown_mode_lo = frame_word[quad_dac_pkg::PD_MODE_LO_POS];
   // Low four bits are never looked at
   wire [11:0] data_field = frame_word[quad_dac_pkg::DATA_MSB_POS:quad_dac_pkg::DATA_LSB_POS];
   // Bit 19 is assumed zero by the host and not decoded

   // Mode code from the power-down bits
   // Limitation: an undefined code cannot be told apart from high impedance later
   quad_dac_pkg::out_mode_t frame_mode;
   always_comb begin
      if (!powerdown_flag) begin
         frame_mode = quad_dac_pkg::MODE_NORMAL;
      end else begin
         case ({powerdown_mode_hi, powerdown_mode_lo})
            2'b01:   frame_mode = quad_dac_pkg::MODE_1K;
            2'b10:   frame_mode = quad_dac_pkg::MODE_100K;
            2'b11:   frame_mode = quad_dac_pkg::MODE_HIZ;
            // Code 00 is undefined; treated as high impedance, safest output
            default: frame_mode = quad_dac_pkg::MODE_HIZ;
         endcase
      end
   end

   // Buffers hold data and mode; registers drive the outputs
   // Output registers are read back through these aliases for the next values
   logic [11:0] buf_data_ff [NC];
   logic [1:0]  buf_mode_ff [NC];
   logic [11:0] dac_data    [NC];
   logic [1:0]  dac_mode    [NC];
   assign dac_data[0] = dac_a_ff;
   assign dac_data[1] = dac_b_ff;
   assign dac_data[2] = dac_c_ff;
   assign dac_data[3] = dac_d_ff;
   assign dac_mode[0] = mode_a_ff;
   assign dac_mode[1] = mode_b_ff;
   assign dac_mode[2] = mode_c_ff;
   assign dac_mode[3] = mode_d_ff;

   // Per-channel decisions for this frame
   // At most one of ld_frm and ld_buf is set for any channel
   logic [NC-1:0] wr_buf;  // Buffer takes frame contents
   logic [NC-1:0] ld_frm;  // DAC register takes frame contents
   logic [NC-1:0] ld_buf;  // DAC register takes its own buffer
   always_comb begin
      wr_buf = '0;
      ld_frm = '0;
      ld_buf = '0;
      case (quad_dac_pkg::load_cmd_t'({load_ctrl_hi, load_ctrl_lo}))
         quad_dac_pkg::LOAD_STORE: begin
            wr_buf[sel] = 1'b1;
         end
         quad_dac_pkg::LOAD_SINGLE: begin
            wr_buf[sel] = 1'b1;
            ld_frm[sel] = 1'b1;
         end
         quad_dac_pkg::LOAD_ALL: begin
            wr_buf[sel] = 1'b1;
            ld_frm[sel] = 1'b1;
            ld_buf      = ~ld_frm;
         end
         default: begin
            if (!sel[1]) begin
               ld_buf = '1;
            end else begin
               wr_buf = '1;
               ld_frm = '1;
            end
         end
      endcase
   end

   // Buffer data; only a complete frame event writes it
   // A power-down frame leaves the stored code alone, so a later wake-up restores it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NC; i++) begin
            buf_data_ff[i] <= quad_dac_pkg::DATA_RESET;
         end
      end else if (frame_evt) begin
         for (int i = 0; i < NC; i++) begin
            // Power-down keeps stored data; only the mode changes
            if (wr_buf[i] && !powerdown_flag) begin
               buf_data_ff[i] <= data_field;
            end
         end
      end
   end

   // Buffer mode; kept beside the data so a reload restores power-down too
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NC; i++) begin
            buf_mode_ff[i] <= quad_dac_pkg::MODE_NORMAL;
         end
      end else if (frame_evt) begin
         for (int i = 0; i < NC; i++) begin
            if (wr_buf[i]) begin
               buf_mode_ff[i] <= frame_mode;
            end
         end
      end
   end

   // Next values of the DAC registers
   logic [11:0] nxt_data [NC];
   logic [1:0]  nxt_mode [NC];
   always_comb begin
      for (int i = 0; i < NC; i++) begin
         nxt_data[i] = dac_data[i];
         nxt_mode[i] = dac_mode[i];
         if (ld_frm[i]) begin
            if (!powerdown_flag) nxt_data[i] = data_field;
            nxt_mode[i] = frame_mode;
         end else if (ld_buf[i]) begin
            nxt_data[i] = buf_data_ff[i];
            nxt_mode[i] = buf_mode_ff[i];
         end
      end
   end

   // DAC data registers load together on the frame event
   // All four share one enable, so a simultaneous update never shows a mix
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dac_a_ff <= quad_dac_pkg::DATA_RESET;
         dac_b_ff <= quad_dac_pkg::DATA_RESET;
         dac_c_ff <= quad_dac_pkg::DATA_RESET;
         dac_d_ff <= quad_dac_pkg::DATA_RESET;
      end else if (frame_evt) begin
         dac_a_ff <= nxt_data[0];
         dac_b_ff <= nxt_data[1];
         dac_c_ff <= nxt_data[2];
         dac_d_ff <= nxt_data[3];
      end
   end

   // Operating modes load in the same cycle as the data
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_a_ff <= quad_dac_pkg::MODE_NORMAL;
         mode_b_ff <= quad_dac_pkg::MODE_NORMAL;
         mode_c_ff <= quad_dac_pkg::MODE_NORMAL;
         mode_d_ff <= quad_dac_pkg::MODE_NORMAL;
      end else if (frame_evt) begin
         mode_a_ff <= nxt_mode[0];
         mode_b_ff <= nxt_mode[1];
         mode_c_ff <= nxt_mode[2];
         mode_d_ff <= nxt_mode[3];
      end
   end

   // One-cycle marker that a frame was executed
   // Lands in the same cycle as the new outputs, so a watcher can sample them then
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) update_pulse_ff <= 1'b0;
      else        update_pulse_ff <= frame_evt;
   end
endmodule
`default_nettype wire

// ### hw/quad_dac_pkg.sv
// Purpose: Shared constants for the quad DAC serial command decoder.
// Assumes: 24-bit frames, MSB first, sampled on falling serial-clock edges.
// Notes:   Field positions are bit indices within the completed frame.
// How it works
// - Load bits 00, no power-down: buffer only
// - Load 00 with power-down: buffer holds command
// - Load 01: buffer and selected DAC register
// - Load 10: buffer, then all DACs together
// - Load 11, select high 0: reload all
// - Load 11, select high 1: data everywhere
// - Load 11, select high 1, power-down everywhere
// - Update happens on the 24th falling edge; outputs load on the third rising core-clock edge after it
// - Early strobe rise clears and discards frame
// - Aborted frame changes nothing at all
// - Sample MSB first, ignore clocks after 24
// - Four lowest frame bits are ignored
// - Power-down flag plus two bits select mode
package quad_dac_pkg;
   localparam int FRAME_BITS      = 24;   // Shift register length
   localparam int DATA_BITS       = 12;   // Data field width
   localparam int CHANNELS        = 4;    // Number of channels
   localparam int LOAD_HI_POS     = 21;   // Load control, upper bit
   localparam int LOAD_LO_POS     = 20;   // Load control, lower bit
   localparam int SEL_HI_POS      = 18;   // Channel select, upper bit
   localparam int SEL_LO_POS      = 17;   // Channel select, lower bit
   localparam int PD_FLAG_POS     = 16;   // Power-down flag
   localparam int PD_MODE_HI_POS  = 15;   // Power-down mode, upper bit
   localparam int PD_MODE_LO_POS  = 14;   // Power-down mode, lower bit
   localparam int DATA_MSB_POS    = 15;   // Top of data field
   localparam int DATA_LSB_POS    = 4;    // Bottom of data field
   localparam logic [11:0] DATA_RESET = 12'h000; // Value after reset

   // Output operating mode of one channel
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_1K     = 2'b01,
      MODE_100K   = 2'b10,
      MODE_HIZ    = 2'b11
   } out_mode_t;

   // Load-control actions
   typedef enum logic [1:0] {
      LOAD_STORE  = 2'b00,
      LOAD_SINGLE = 2'b01,
      LOAD_ALL    = 2'b10,
      LOAD_BCAST  = 2'b11
   } load_cmd_t;
endpackage

// ### tb/dac_host_model.sv
// Purpose: Host side of the serial link, sending one frame per call.
// Assumes: Link clock idles high and stands still between frames.
// Notes:   Caller chooses edge count; below 24 aborts the frame.
`timescale 1ns/1ps
`default_nettype none
module dac_host_model (
   output var logic sclk,
   output var logic sync_n,
   output var logic sdin
);
   // Idle levels before any frame
   initial begin
      sclk = 1'b1;
      sync_n = 1'b1;
      sdin = 1'b0;
   end
   // MSB first, 80 ns link period; data moves while the clock is high
   task automatic send(input logic [23:0] w, input int n);
      logic [31:0] s;
      s = {w, 8'h00};
      #13 sync_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         sdin = s[31];
         s = s << 1;
         #40 sclk = 1'b0;
         #40 sclk = 1'b1;
      end
      #40 sync_n = 1'b1;
      // Released line must not show a stale bit
      sdin = ~sdin;
   endtask
endmodule
`default_nettype wire

// ### tb/quad_dac_command_decoder_properties.sv
// Purpose: Port checks of the command decoder.
// Assumes: Frame mirror below tracks the link edges.
// Notes:   Mirror clears on strobe high, like the device.
`timescale 1ns/1ps
`default_nettype none
module quad_dac_command_decoder_properties (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        sclk,
   input wire logic        sync_n,
   input wire logic        sdin,
   input wire logic [11:0] dac_a_ff,
   input wire logic [11:0] dac_b_ff,
   input wire logic [11:0] dac_c_ff,
   input wire logic [11:0] dac_d_ff,
   input wire logic [1:0]  mode_a_ff,
   input wire logic [1:0]  mode_b_ff,
   input wire logic [1:0]  mode_c_ff,
   input wire logic [1:0]  mode_d_ff,
   input wire logic        update_pulse_ff
);
   logic [23:0] sr_ff;  // Mirror of the frame
   logic [4:0]  cnt_ff; // Edges taken
   logic        done;   // Frame complete
   logic [11:0] dat;    // Data field
   logic [55:0] outs;   // All outputs together
   assign done = (cnt_ff == 5'h18);
   assign dat = sr_ff[15:4];
   assign outs = {dac_a_ff, dac_b_ff, dac_c_ff, dac_d_ff, mode_a_ff, mode_b_ff, mode_c_ff, mode_d_ff};
   // Shift on falling link clock; stops after 24 so extra clocks are ignored
   always_ff @(negedge sclk or posedge sync_n or negedge rst_n) begin
      if (!rst_n || sync_n) begin
         cnt_ff <= 5'h00;
         sr_ff <= 24'h000000;
      end else if (!done) begin
         cnt_ff <= cnt_ff + 5'h01;
         sr_ff <= {sr_ff[22:0], sdin};
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_pulse_one_cycle: assert property (update_pulse_ff |=> !update_pulse_ff)
      else $error("update pulse too long");
   a_update_on_time: assert property ($rose(done) |-> ##[1:6] update_pulse_ff)
      else $error("update late after last edge");
   a_abort_no_pulse: assert property (update_pulse_ff |-> done)
      else $error("update without complete frame");
   a_outputs_hold: assert property (!update_pulse_ff |-> $stable(outs))
      else $error("outputs moved without update");
   a_store_only: assert property (update_pulse_ff && sr_ff[21:20] == 2'b00 |-> $stable(outs))
      else $error("store changed outputs");
   a_single_load: assert property (update_pulse_ff && sr_ff[21:16] == 6'h10 |-> dac_a_ff == dat && mode_a_ff == 2'h0)
      else $error("single load of channel a wrong");
   a_bcast_data: assert property (update_pulse_ff && sr_ff[21:20] == 2'h3 && sr_ff[18] && !sr_ff[16]
      |-> dac_a_ff == dat && dac_d_ff == dat)
      else $error("broadcast data wrong");
   a_bcast_mode: assert property (update_pulse_ff && sr_ff[21:20] == 2'h3 && sr_ff[18:16] == 3'h5 && sr_ff[15:14] == 2'h1
      |-> mode_b_ff == 2'h1 && mode_c_ff == 2'h1)
      else $error("broadcast mode wrong");
endmodule
bind quad_dac_command_decoder quad_dac_command_decoder_properties chk_i (
   .core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
   .dac_a_ff(dac_a_ff), .dac_b_ff(dac_b_ff), .dac_c_ff(dac_c_ff), .dac_d_ff(dac_d_ff),
   .mode_a_ff(mode_a_ff), .mode_b_ff(mode_b_ff), .mode_c_ff(mode_c_ff), .mode_d_ff(mode_d_ff),
   .update_pulse_ff(update_pulse_ff));
`default_nettype wire

// ### tb/tb_quad_dac_command_decoder.sv
// Purpose: Self-checking bench of the command decoder.
// Assumes: One frame in flight; outputs settle within 4 core cycles.
// Notes:   Reference model keeps buffers and registers per channel.
`timescale 1ns/1ps
`default_nettype none
module tb_quad_dac_command_decoder;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   wire logic   sclk, sync_n, sdin;
   logic [11:0] dac [4], bd [4], rd [4]; // Outputs, model buffers and registers
   logic [1:0]  mode [4], bm [4], rm [4];
   logic        update_pulse_ff;
   logic [31:0] seed = 32'h00000035;
   logic [31:0] r;
   int          n, pulses = 0, num_errors = 0, check_count = 0;
   always #2 core_clk = ~core_clk;
   dac_host_model dac_host_model_i (.sclk(sclk), .sync_n(sync_n), .sdin(sdin));
   quad_dac_command_decoder quad_dac_command_decoder_i (
      .core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
      .dac_a_ff(dac[0]), .dac_b_ff(dac[1]), .dac_c_ff(dac[2]), .dac_d_ff(dac[3]),
      .mode_a_ff(mode[0]), .mode_b_ff(mode[1]), .mode_c_ff(mode[2]), .mode_d_ff(mode[3]),
      .update_pulse_ff(update_pulse_ff));
   // Count update pulses seen by the core clock
   always @(posedge core_clk) if (update_pulse_ff === 1'b1) pulses++;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [23:0] mk(logic [1:0] ld, logic [1:0] sel, logic pd, logic [11:0] d);
      return {2'b00, ld, 1'b0, sel, pd, d, 4'h5};
   endfunction
   // Buffer write; power-down keeps data, mode 00 reads as high impedance
   function automatic void wr(int c, logic [23:0] f);
      if (f[16]) bm[c] = (f[15:14] == 2'b00) ? 2'b11 : f[15:14];
      else begin
         bd[c] = f[15:4];
         bm[c] = 2'b00;
      end
   endfunction
   function automatic void apply(logic [23:0] f);
      int s;
      s = f[18:17];
      if (f[21:20] != 2'b11) wr(s, f);
      else if (f[18]) for (int c = 0; c < 4; c++) wr(c, f);
      if (f[21:20] == 2'b01) begin
         rd[s] = bd[s];
         rm[s] = bm[s];
      end else if (f[21]) begin
         rd = bd;
         rm = bm;
      end
   endfunction
   task automatic chk(string nm, logic [13:0] e, logic [13:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One frame of n edges, then compare pulse count and every channel
   task automatic run(logic [23:0] f, int k);
      int p;
      p = pulses;
      dac_host_model_i.send(f, k);
      repeat (4) @(posedge core_clk);
      if (k >= 24) apply(f);
      chk("pulses", 14'(k >= 24), 14'(pulses - p));
      for (int c = 0; c < 4; c++) chk("channel", {rm[c], rd[c]}, {mode[c], dac[c]});
   endtask
   task end_sim;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      for (int c = 0; c < 4; c++) {bd[c], rd[c], bm[c], rm[c]} = 28'h0;
      repeat (10) @(posedge core_clk);
      #1 rst_n = 1'b1;
      run(24'h000000, 0);
      run(mk(2'b00, 2'b00, 1'b0, 12'habc), 24);
      run(mk(2'b00, 2'b01, 1'b1, 12'h400), 24);
      run(mk(2'b01, 2'b10, 1'b0, 12'h123), 24);
      run(mk(2'b01, 2'b00, 1'b0, 12'h7e1), 25);
      run(mk(2'b10, 2'b11, 1'b0, 12'hfff), 24);
      run(mk(2'b11, 2'b00, 1'b0, 12'h0ff), 26);
      run(mk(2'b01, 2'b11, 1'b0, 12'h001), 23);
      run(mk(2'b11, 2'b10, 1'b0, 12'h456), 24);
      run(mk(2'b11, 2'b11, 1'b1, 12'h800), 24);
      run(mk(2'b11, 2'b10, 1'b1, 12'h400), 24);
      run(mk(2'b01, 2'b01, 1'b1, 12'hc00), 24);
      run(mk(2'b10, 2'b00, 1'b1, 12'h000), 24);
      run(mk(2'b01, 2'b10, 1'b1, 12'h000), 1);
      repeat (40) begin
         r = xs();
         n = (r[31:30] == 2'b00) ? 1 + r[27:24] : 24 + r[29:28] % 3;
         run({r[23:20], 1'b0, r[18:0]}, n);
      end
      end_sim;
   end
   // Complete frames take about 2 us each
   initial begin
      #300us;
      num_errors++;
      end_sim;
   end
endmodule
`default_nettype wire
